/* design/spc_pkg.sv */
package spc_pkg;
	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] SPC_OFS_CTRL1 = 8'h00;
	localparam logic [7:0] SPC_OFS_CTRL2 = 8'h04;
	localparam logic [7:0] SPC_OFS_BAUD  = 8'h08;
	localparam logic [7:0] SPC_OFS_STAT  = 8'h0c;
	localparam logic [7:0] SPC_OFS_DATA  = 8'h10;
	localparam logic [7:0] SPC_OFS_IRQST = 8'h14;
	localparam logic [7:0] SPC_OFS_IRQMK = 8'h18;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int C1_RXIE    = 7;
	localparam int C1_EN      = 6;
	localparam int C1_TXIE    = 5;
	localparam int C1_ROLE    = 4;
	localparam int C1_CLOCK_POLARITY    = 3;
	localparam int C1_CLOCK_PHASE    = 2;
	localparam int C1_SELECT_OUTPUT_ENABLE    = 1;
	localparam int C1_LSB     = 0;
	localparam int C2_MODE_FAULT_ENABLE  = 4;
	localparam int C2_SINGLE_WIRE_OUTPUT_ENABLE = 3;
	localparam int C2_WSTOP   = 1;
	localparam int C2_SWIRE   = 0;
	localparam int ST_RXF     = 7;
	localparam int ST_TXE     = 5;
	localparam int ST_MODE_FAULT_FLAG    = 4;
	localparam int IQ_RX      = 0;
	localparam int IQ_MODE_FAULT_FLAG    = 1;
	localparam int IQ_TX      = 2;
	// ****************************************
	// Reset values, masks, counts
	// ****************************************
	localparam logic [7:0] SPC_C1_RST    = 8'h04;
	localparam logic [7:0] SPC_C2_RST    = 8'h00;
	localparam logic [7:0] SPC_BR_RST    = 8'h00;
	localparam logic [7:0] SPC_C2_MASK   = 8'h1b;
	localparam logic [7:0] SPC_BR_MASK   = 8'h77;
	localparam logic [2:0] SPC_MSK_RST   = 3'h7;
	localparam logic [3:0] SPC_LAST_EDGE = 4'hf;
	typedef enum logic [2:0] {
		SPC_IDLE = 3'b001,
		SPC_XFER = 3'b010,
		SPC_DONE = 3'b100
	} spc_state_e;
endpackage

/* design/spc_core.sv */
`timescale 1ns/1ps
module spc_core
	import spc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	output logic             irq_o,
	input  wire logic        stop_deep_i,
	input  wire logic        stop_light_i,
	input  wire logic        wait_i,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe_o,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe_o
);
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0]  c1_q;
	logic [7:0]  c2_q;
	logic [7:0]  br_q;
	logic [7:0]  txbuf_q;
	logic [7:0]  rxbuf_q;
	logic [7:0]  shift_q;
	logic        txe_q;
	logic        rxf_q;
	logic        mode_fault_flag_q;
	logic        arm_tx_q;
	logic        arm_rx_q;
	logic        arm_mode_fault_flag_q;
	logic [2:0]  irqst_q;
	logic [2:0]  irqmk_q;
	logic        bit_q;
	logic [3:0]  edge_q;
	logic [11:0] div_q;
	logic        lvl_q;
	logic [3:0]  pin_s1_q;
	logic [3:0]  pin_s2_q;
	logic        sck_prev_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        irq_q;
	logic        sck_q;
	logic        sck_oe_q;
	logic        mosi_q;
	logic        mosi_oe_q;
	logic        miso_q;
	logic        miso_oe_q;
	logic        ss_q;
	logic        ss_oe_q;
	spc_state_e  state_q;
	spc_state_e  state_d;

	// ****************************************
	// Bus decode
	// ****************************************
	wire srst     = rst_i | stop_deep_i;
	wire req      = cyc_i & stb_i;
	wire act      = req & ack_q;
	wire wr_act   = act & we_i & sel_i[0];
	wire rd_act   = act & !we_i;
	wire hit_c1   = adr_i == SPC_OFS_CTRL1;
	wire hit_c2   = adr_i == SPC_OFS_CTRL2;
	wire hit_br   = adr_i == SPC_OFS_BAUD;
	wire hit_st   = adr_i == SPC_OFS_STAT;
	wire hit_dat  = adr_i == SPC_OFS_DATA;
	wire hit_iqs  = adr_i == SPC_OFS_IRQST;
	wire hit_iqm  = adr_i == SPC_OFS_IRQMK;

	// ****************************************
	// Mode decode
	// ****************************************
	wire en       = c1_q[C1_EN];
	wire master   = c1_q[C1_ROLE];
	wire clock_polarity     = c1_q[C1_CLOCK_POLARITY];
	wire clock_phase     = c1_q[C1_CLOCK_PHASE];
	wire lsb      = c1_q[C1_LSB];
	wire mode_fault_enable   = c2_q[C2_MODE_FAULT_ENABLE];
	wire swire    = c2_q[C2_SWIRE];
	wire drive_ok = !swire | c2_q[C2_SINGLE_WIRE_OUTPUT_ENABLE];
	// Frozen engine keeps every counter and shifter as it was
	wire halt     = stop_light_i | (wait_i & c2_q[C2_WSTOP]);
	wire run      = en & !halt;
	wire sck_s    = pin_s2_q[3];
	wire mosi_s   = pin_s2_q[2];
	wire miso_s   = pin_s2_q[1];
	wire ss_s     = pin_s2_q[0];
	wire slv_sel  = !master & !ss_s;
	wire flt_in   = master & mode_fault_enable & !c1_q[C1_SELECT_OUTPUT_ENABLE];
	wire auto_ss  = master & mode_fault_enable & c1_q[C1_SELECT_OUTPUT_ENABLE];
	wire mode_fault_flag_evt = en & flt_in & !ss_s;
	wire in_bit   = master ? (swire ? mosi_s : miso_s)
	                       : (swire ? miso_s : mosi_s);
	wire out_bit  = lsb ? shift_q[0] : shift_q[7];
	wire [7:0] shifted = lsb ? {bit_q, shift_q[7:1]}
	                         : {shift_q[6:0], bit_q};

	// ****************************************
	// Edge generation
	// ****************************************
	// Half bit time: prescale (1..8) times rate/2 (1..128)
	wire [3:0]  pre_w  = 4'({1'b0, br_q[6:4]} + 4'h1);
	wire [11:0] half_w = {8'h00, pre_w} << br_q[2:0];
	wire in_xfer  = state_q == SPC_XFER;
	wire m_edge   = div_q == 12'h000;
	wire s_edge   = sck_s != sck_prev_q;
	wire edge_ev  = run & in_xfer & (master ? m_edge : s_edge);
	wire last_ev  = edge_ev & (edge_q == SPC_LAST_EDGE);
	// Phase 0 samples on leading edges, phase 1 on trailing
	wire smp_ev   = edge_ev & (edge_q[0] == clock_phase);
	// Phase 1 has no data change on its very first edge
	wire shf_ev   = edge_ev & (edge_q[0] != clock_phase)
	                & !(clock_phase & edge_q == 4'h0);
	wire abort    = !en | mode_fault_flag_evt | (!master & ss_s);
	wire start    = (state_q == SPC_IDLE) & run & !mode_fault_flag_evt
	                & (master ? !txe_q : slv_sel);
	wire tx_load  = start & !txe_q;
	wire done     = state_q == SPC_DONE;
	// Phase 1 still owes the last shift when the final edge falls
	wire [7:0] rx_word = clock_phase ? shifted : shift_q;

	// ****************************************
	// Interrupt sources
	// ****************************************
	wire [2:0] irq_src;
	assign irq_src[IQ_RX]   = rxf_q & c1_q[C1_RXIE];
	assign irq_src[IQ_MODE_FAULT_FLAG] = mode_fault_flag_q & c1_q[C1_RXIE];
	assign irq_src[IQ_TX]   = txe_q & c1_q[C1_TXIE];
	// Read clears only the bits software actually saw
	wire [2:0] iq_clr = (rd_act & hit_iqs) ? dat_q[2:0] : 3'h0;

	// ****************************************
	// Read data
	// ****************************************
	wire [7:0] st_byte = {rxf_q, 1'b0, txe_q, mode_fault_flag_q, 4'h0};
	wire [7:0] rd_byte =
		hit_c1  ? c1_q :
		hit_c2  ? (c2_q & SPC_C2_MASK) :
		hit_br  ? br_q :
		hit_st  ? st_byte :
		hit_dat ? rxbuf_q :
		hit_iqs ? {5'h00, irqst_q} :
		hit_iqm ? {5'h00, irqmk_q} : 8'h00;

	// ****************************************
	// Wishbone slave
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (srst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & !ack_q;
			dat_q <= {24'h00_0000, rd_byte};
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (srst) begin
			c1_q    <= SPC_C1_RST;
			c2_q    <= SPC_C2_RST;
			br_q    <= SPC_BR_RST;
			irqmk_q <= SPC_MSK_RST;
		end else if (wr_act) begin
			if (hit_c1)
				c1_q <= dat_i[7:0];
			if (hit_c2)
				c2_q <= dat_i[7:0] & SPC_C2_MASK;
			if (hit_br)
				br_q <= dat_i[7:0] & SPC_BR_MASK;
			if (hit_iqm)
				irqmk_q <= dat_i[2:0];
		end
	end

	// ****************************************
	// Flags and buffers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (srst) begin
			txbuf_q    <= 8'h00;
			rxbuf_q    <= 8'h00;
			txe_q      <= 1'b1;
			rxf_q      <= 1'b0;
			mode_fault_flag_q     <= 1'b0;
			arm_tx_q   <= 1'b0;
			arm_rx_q   <= 1'b0;
			arm_mode_fault_flag_q <= 1'b0;
			irqst_q    <= 3'h0;
		end else begin
			irqst_q <= (irqst_q & ~iq_clr) | irq_src;
			if (rd_act & hit_st) begin
				arm_tx_q   <= dat_q[ST_TXE];
				arm_rx_q   <= dat_q[ST_RXF];
				arm_mode_fault_flag_q <= dat_q[ST_MODE_FAULT_FLAG];
			end
			if (wr_act & hit_dat & arm_tx_q) begin
				txbuf_q  <= dat_i[7:0];
				txe_q    <= 1'b0;
				arm_tx_q <= 1'b0;
			end
			if (tx_load)
				txe_q <= 1'b1;
			if (rd_act & hit_dat & arm_rx_q) begin
				rxf_q    <= 1'b0;
				arm_rx_q <= 1'b0;
			end
			if (done) begin
				rxbuf_q <= rx_word;
				rxf_q   <= 1'b1;
			end
			if (wr_act & hit_c1 & arm_mode_fault_flag_q) begin
				mode_fault_flag_q     <= 1'b0;
				arm_mode_fault_flag_q <= 1'b0;
			end
			if (mode_fault_flag_evt)
				mode_fault_flag_q <= 1'b1;
			if (!en) begin
				txe_q   <= 1'b1;
				rxf_q   <= 1'b0;
				txbuf_q <= 8'h00;
				rxbuf_q <= 8'h00;
			end
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SPC_IDLE: begin
				if (start)
					state_d = SPC_XFER;
			end
			SPC_XFER: begin
				if (abort)
					state_d = SPC_IDLE;
				else if (last_ev)
					state_d = SPC_DONE;
			end
			SPC_DONE: begin
				state_d = SPC_IDLE;
			end
			default: begin
				state_d = SPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst)
			state_q <= SPC_IDLE;
		else
			state_q <= state_d;
	end

	// ****************************************
	// Shifter and bit clock
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (srst) begin
			shift_q <= 8'h00;
			bit_q   <= 1'b0;
			edge_q  <= 4'h0;
			div_q   <= 12'h000;
			lvl_q   <= 1'b0;
		end else begin
			if (start) begin
				edge_q <= 4'h0;
				div_q  <= 12'(half_w - 12'h001);
				if (tx_load)
					shift_q <= txbuf_q;
			end
			if (run & in_xfer)
				div_q <= m_edge ? 12'(half_w - 12'h001)
				                : 12'(div_q - 12'h001);
			if (edge_ev)
				edge_q <= 4'(edge_q + 4'h1);
			if (smp_ev)
				bit_q <= in_bit;
			if (shf_ev)
				shift_q <= shifted;
			lvl_q <= (in_xfer & !abort) ? (lvl_q ^ edge_ev) : 1'b0;
		end
	end

	// ****************************************
	// Pin synchronisers and drivers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (srst) begin
			pin_s1_q   <= 4'hf;
			pin_s2_q   <= 4'hf;
			// Same level as the synchroniser so reset gives no false edge
			sck_prev_q <= 1'b1;
		end else begin
			pin_s1_q   <= {serial_clock_pin_i, mosi_i, miso_i, ss_n_i};
			pin_s2_q   <= pin_s1_q;
			sck_prev_q <= pin_s2_q[3];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst) begin
			sck_q     <= 1'b0;
			sck_oe_q  <= 1'b0;
			mosi_q    <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_q    <= 1'b0;
			miso_oe_q <= 1'b0;
			ss_q      <= 1'b1;
			ss_oe_q   <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			sck_q     <= clock_polarity ^ lvl_q;
			sck_oe_q  <= en & master;
			mosi_q    <= out_bit;
			mosi_oe_q <= en & master & drive_ok;
			miso_q    <= out_bit;
			miso_oe_q <= en & slv_sel & drive_ok;
			ss_q      <= state_q == SPC_IDLE;
			ss_oe_q   <= en & auto_ss;
			irq_q     <= |(irqst_q & irqmk_q);
		end
	end

	assign dat_o                 = dat_q;
	assign ack_o                 = ack_q;
	assign irq_o                 = irq_q;
	assign serial_clock_pin_o    = sck_q;
	assign serial_clock_pin_oe_o = sck_oe_q;
	assign mosi_o                = mosi_q;
	assign mosi_oe_o             = mosi_oe_q;
	assign miso_o                = miso_q;
	assign miso_oe_o             = miso_oe_q;
	assign ss_n_o                = ss_q;
	assign ss_n_oe_o             = ss_oe_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst);

	sequence s_last;
		last_ev && !abort;
	endsequence
	sequence s_done_en;
		done && en;
	endsequence

	AST_SS_SLAVE_IN: assert property (
		(!master) |=> !ss_n_oe_o
	) else $error("select pin driven in slave mode");
	AST_SS_AUTO_OUT: assert property (
		(en && auto_ss) |=> ss_n_oe_o
	) else $error("select output not driven");
	AST_SS_GPIO: assert property (
		(master && !mode_fault_enable) |=> !ss_n_oe_o
	) else $error("select pin not released");
	AST_DEEP_STOP: assert property (
		$fell(stop_deep_i) |-> c1_q == SPC_C1_RST && txe_q
	) else $error("deep stop did not reset");
	AST_LIGHT_FREEZE: assert property (
		stop_light_i |=> $stable(edge_q) && $stable(shift_q)
	) else $error("engine moved in light stop");
	AST_RX_DONE: assert property (
		s_last ##1 s_done_en |=> rxf_q
	) else $error("receive flag not set");
	AST_IRQ_RX: assert property (
		(rxf_q && c1_q[C1_RXIE] && irqmk_q[IQ_RX]) ##1 irqmk_q[IQ_RX]
		|-> ##1 irq_o
	) else $error("receive interrupt missing");
	AST_DISABLE: assert property (
		!en |=> txe_q && !rxf_q && state_q == SPC_IDLE
	) else $error("disable did not clear state");
	AST_IRQ_TX: assert property (
		(txe_q && c1_q[C1_TXIE] && irqmk_q[IQ_TX]) ##1 irqmk_q[IQ_TX]
		|-> ##1 irq_o
	) else $error("transmit interrupt missing");
	AST_SCK_IDLE: assert property (
		(state_q == SPC_IDLE) |=> serial_clock_pin_o == $past(clock_polarity)
	) else $error("serial clock not at idle level");
	AST_C2_ZERO: assert property (
		(req && !ack_q && hit_c2) |=> dat_o[7:5] == 3'h0 && !dat_o[2]
	) else $error("unused control bits read nonzero");
	AST_BIDIR_OFF: assert property (
		(swire && !c2_q[C2_SINGLE_WIRE_OUTPUT_ENABLE]) |=> !mosi_oe_o && !miso_oe_o
	) else $error("shared pin driven as input");
	AST_WAIT_STOP: assert property (
		(wait_i && c2_q[C2_WSTOP]) |=> $stable(edge_q)
	) else $error("engine moved in wait stop");
	AST_MODE_FAULT_FLAG_SET: assert property (
		mode_fault_flag_evt |=> mode_fault_flag_q
	) else $error("mode fault not flagged");
endmodule

/* tb/spc_peer.sv */
`timescale 1ns/1ps
module spc_peer (
	input  wire logic       sclk_i,
	input  wire logic       sel_n_i,
	input  wire logic       mosi_i,
	input  wire logic       clock_polarity_i,
	input  wire logic       clock_phase_i,
	input  wire logic       lsb_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	int   b;
	logic o;
	// Released line shows the inverse so a stale level cannot pass
	assign miso_o = sel_n_i ? ~o : o;
	function automatic int pos(input int k);
		return lsb_i ? k : 7 - k;
	endfunction
	initial begin
		b = 0;
		o = 1'b0;
		rx_o = 8'h00;
	end
	always @(negedge sel_n_i) begin
		b = 0;
		o = tx_i[pos(0)];
	end
	// Sample on leading edge unless phase set; shift on the other
	always @(sclk_i) begin
		if (!sel_n_i && b < 8) begin
			if ((sclk_i !== clock_polarity_i) ^ clock_phase_i) begin
				rx_o[pos(b)] = mosi_i;
				b = b + 1;
			end else begin
				o = tx_i[pos(b)];
			end
		end
	end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import spc_pkg::*;
	logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o;
	logic        stop_deep_i, stop_light_i, wait_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0]  sel_i;
	logic        sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, ss_o, ss_oe;
	logic        t_sck, t_mo, t_ss, p_mi, clock_polarity, clock_phase, lsb;
	logic [7:0]  ptx, prx;
	logic [8:0]  q[$];
	logic [8:0]  note;
	int          bad_count, num_checks;
	wire         sck_w = sck_oe ? sck_o : t_sck;
	wire         mo_w  = mo_oe ? mo_o : t_mo;
	wire         mi_w  = mi_oe ? mi_o : p_mi;
	wire         ss_w  = ss_oe ? ss_o : t_ss;
	spc_core spc_core_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
		.dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_o(irq_o),
		.stop_deep_i(stop_deep_i), .stop_light_i(stop_light_i),
		.wait_i(wait_i), .serial_clock_pin_i(sck_w),
		.serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
		.mosi_i(mo_w), .mosi_o(mo_o), .mosi_oe_o(mo_oe), .miso_i(mi_w),
		.miso_o(mi_o), .miso_oe_o(mi_oe), .ss_n_i(ss_w), .ss_n_o(ss_o),
		.ss_n_oe_o(ss_oe));
	spc_peer spc_peer_i (.sclk_i(sck_w), .sel_n_i(ss_w), .mosi_i(mo_w),
		.clock_polarity_i(clock_polarity), .clock_phase_i(clock_phase), .lsb_i(lsb), .tx_i(ptx),
		.miso_o(p_mi), .rx_o(prx));
	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cb(input logic g, input logic e);
		cmp({7'h00, g}, {7'h00, e});
	endtask
	task automatic bus(input logic [7:0] a, input logic [7:0] d,
		input logic w, input logic c, input logic [7:0] e,
		output logic [7:0] r);
		int n;
		if (!w) q.push_back({c, e});
		adr_i <= a;
		dat_i <= {24'h000000, d};
		we_i  <= w;
		sel_i <= 4'hf;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		r = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(a, d, 1'b1, 1'b0, 8'h00, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		bus(a, 8'h00, 1'b0, 1'b1, e, r);
	endtask
	task automatic rdn(input logic [7:0] a, output logic [7:0] r);
		bus(a, 8'h00, 1'b0, 1'b0, 8'h00, r);
	endtask
	task automatic rst_chk();
		rd(SPC_OFS_CTRL1, 8'h04);
		rd(SPC_OFS_CTRL2, 8'h00);
		rd(SPC_OFS_STAT, 8'h20);
		rd(SPC_OFS_IRQMK, 8'h07);
		rd(8'h1c, 8'h00);
	endtask
	// Engine frozen mid byte: clock pin must not move
	task automatic frz(input int k);
		logic s;
		repeat (8) @(posedge clk_i);
		if (k == 0) stop_light_i <= 1'b1;
		else wait_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		s = sck_o;
		repeat (20) @(posedge clk_i);
		cb(sck_o, s);
		stop_light_i <= 1'b0;
		wait_i <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) begin
			note = q.pop_front();
			if (note[8]) cmp(dat_o[7:0], note[7:0]);
		end
	end
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] r, d, c1;
		int i, n;
		{we_i, cyc_i, stb_i, stop_deep_i, stop_light_i, wait_i} = 6'h00;
		{adr_i, dat_i, sel_i} = '0;
		{t_sck, t_mo, t_ss, clock_polarity, clock_phase, lsb} = 6'h0b;
		ptx = 8'h00;
		rst_i = 1'b1;
		void'($urandom(32'hcae2e986));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rst_chk();
		wr(SPC_OFS_CTRL2, 8'hff);
		rd(SPC_OFS_CTRL2, 8'h1b);
		$display("test registers done");
		for (i = 0; i < 8; i++) begin
			wr(SPC_OFS_CTRL2, {3'h0, i[1], 4'h0});
			wr(SPC_OFS_CTRL1, {2'b01, 1'b0, i[2], 2'b00, i[0], 1'b0});
			repeat (3) @(posedge clk_i);
			cb(ss_oe, i[2] & i[1] & i[0]);
		end
		wr(SPC_OFS_CTRL1, 8'hd0);
		t_ss <= 1'b0;
		repeat (6) @(posedge clk_i);
		t_ss <= 1'b1;
		rd(SPC_OFS_STAT, 8'h30);
		cb(irq_o, 1'b1);
		wr(SPC_OFS_CTRL1, 8'hd0);
		rdn(SPC_OFS_IRQST, r);
		rd(SPC_OFS_STAT, 8'h20);
		cb(irq_o, 1'b0);
		$display("test select pin done");
		wr(SPC_OFS_BAUD, 8'h11);
		for (i = 0; i < 4; i++) begin
			clock_polarity = i[0];
			clock_phase = i[1];
			lsb = i[0] ^ i[1];
			ptx = 8'($urandom);
			d = 8'($urandom);
			wr(SPC_OFS_CTRL2, (i == 1) ? 8'h12 : 8'h10);
			c1 = {4'hd, clock_polarity, clock_phase, 1'b1, lsb};
			wr(SPC_OFS_CTRL1, c1);
			repeat (3) @(posedge clk_i);
			cb(sck_o, clock_polarity);
			cb(sck_oe, 1'b1);
			rd(SPC_OFS_STAT, 8'h20);
			wr(SPC_OFS_DATA, d);
			if (i < 2) frz(i);
			n = 0;
			r = 8'h00;
			while (r[7] !== 1'b1 && n < 200) begin
				rdn(SPC_OFS_STAT, r);
				n++;
			end
			if (r[7] !== 1'b1) bad_count++;
			cb(irq_o, 1'b1);
			rd(SPC_OFS_DATA, ptx);
			cmp(prx, d);
			rdn(SPC_OFS_IRQST, r);
		end
		rd(SPC_OFS_STAT, 8'h20);
		wr(SPC_OFS_DATA, 8'h5a);
		// Enable dropped with phase unchanged, as software must
		wr(SPC_OFS_CTRL1, c1 & 8'hbf);
		rd(SPC_OFS_STAT, 8'h20);
		stop_deep_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		stop_deep_i <= 1'b0;
		@(posedge clk_i);
		rst_chk();
		$display("test master done");
		// Slave byte on a slow link clock driven by the bench
		wr(SPC_OFS_CTRL1, 8'h40);
		rd(SPC_OFS_STAT, 8'h20);
		d = 8'($urandom);
		ptx = 8'($urandom);
		wr(SPC_OFS_DATA, d);
		t_ss <= 1'b0;
		for (i = 7; i >= 0; i--) begin
			t_mo <= ptx[i];
			repeat (16) @(posedge clk_i);
			t_sck <= 1'b1;
			r[i] = mi_w;
			repeat (15) @(posedge clk_i);
			t_sck <= 1'b0;
		end
		repeat (16) @(posedge clk_i);
		t_ss <= 1'b1;
		t_mo <= ~t_mo;
		cmp(r, d);
		rd(SPC_OFS_STAT, 8'ha0);
		rd(SPC_OFS_DATA, ptx);
		$display("test slave done");
		wr(SPC_OFS_CTRL1, 8'h50);
		for (i = 0; i < 3; i++) begin
			wr(SPC_OFS_CTRL2, (i == 0) ? 8'h01 : {4'h0, 4'h7 + i[3:0]});
			repeat (3) @(posedge clk_i);
			cb(mo_oe, i != 0);
			cb(mi_oe, 1'b0);
		end
		wr(SPC_OFS_CTRL2, 8'h00);
		wr(SPC_OFS_CTRL1, 8'h70);
		repeat (3) @(posedge clk_i);
		cb(irq_o, 1'b1);
		wr(SPC_OFS_IRQMK, 8'h00);
		repeat (2) @(posedge clk_i);
		cb(irq_o, 1'b0);
		wr(SPC_OFS_IRQMK, 8'h07);
		wr(SPC_OFS_CTRL1, 8'h50);
		rdn(SPC_OFS_IRQST, r);
		repeat (2) @(posedge clk_i);
		cb(irq_o, 1'b0);
		$display("test pins and interrupts done");
		summarize();
	end
endmodule
